// ### hw/frt_capture_pkg.sv
// package: register map, fields and bus carrier for the capture timer block
package frt_capture_pkg;

  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 32;

  // word indices; byte address is four times the index
  localparam logic [15:0] IDX_CTRL       = 16'hff90;
  localparam logic [15:0] IDX_STATUS     = 16'hff91;
  localparam logic [15:0] IDX_COUNT_HIGH = 16'hff92;
  localparam logic [15:0] IDX_COUNT_LOW  = 16'hff93;
  localparam logic [15:0] IDX_CAPT_HIGH  = 16'hff94;
  localparam logic [15:0] IDX_CAPT_LOW   = 16'hff95;

  // control register fields
  localparam int unsigned CTRL_IRQ_EN_BIT = 7;
  localparam int unsigned CTRL_EDGE_BIT   = 0;

  // status register: bits 7..4 flags, bits 3..0 plain storage
  localparam int unsigned STAT_CAPT_BIT   = 7;
  localparam int unsigned STAT_FLAG_LO    = 4;

  localparam logic [7:0]  CTRL_RESET      = 8'h00;
  localparam logic [7:0]  STATUS_RESET    = 8'h00;
  localparam logic [15:0] COUNT_RESET     = 16'h0000;
  localparam logic [15:0] CAPT_RESET      = 16'h0000;

  // cycles from request to waitrequest low
  localparam int unsigned BUS_LATENCY     = 1;

  typedef struct packed {
    logic [ADDR_W-1:0] address;
    logic              read;
    logic              write;
    logic [DATA_W-1:0] writedata;
    logic [3:0]        byteenable;
  } avmm_req_t;

endpackage

// ### hw/free_running_timer_capture_status.sv
// free-running 16-bit counter with input capture, capture flag and bus slave
// ---------------------------------------------------------------------------
// Notes on behaviour
// - capture interrupt only issued when capture_irq_enable is 1
// - active capture_trigger_pin edge copies running_count into capture_register
// - that same capture sets capture_flag in timer_control_status
// - status bits 7..4 cleared by writing 0; writing 1 does nothing
// - running_count high byte at lower index, low byte at next index
// ---------------------------------------------------------------------------
//
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/100ps
module free_running_timer_capture_status
  import frt_capture_pkg::*;
(
  input  wire logic              clk,                 // 125 MHz system clock
  input  wire logic              sys_rst,             // synchronous, active high
  input  wire avmm_req_t         avs_req,             // avalon request group
  output logic [DATA_W-1:0]      avs_readdata,        // read data, valid with ack
  output logic                   avs_waitrequest,     // low for one cycle = answer
  input  wire logic              capture_trigger_pin, // asynchronous capture input
  output logic                   capture_irq          // capture interrupt request
);

  // -------------------------------------------------------------------------
  // bus handshake
  // -------------------------------------------------------------------------
  logic wait_r;
  logic req;
  logic ack;

  assign req = avs_req.read | avs_req.write;
  assign ack = req & ~wait_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      wait_r <= 1'b1;
    end else begin
      wait_r <= ~(req & wait_r);
    end
  end

  assign avs_waitrequest = wait_r;

  logic wr_byte;
  assign wr_byte = ack & avs_req.write & avs_req.byteenable[0];

  // -------------------------------------------------------------------------
  // control register
  // -------------------------------------------------------------------------
  logic [7:0] ctrl_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ctrl_r <= CTRL_RESET;
    end else if (wr_byte && avs_req.address == IDX_CTRL) begin
      ctrl_r <= avs_req.writedata[7:0];
    end
  end

  // -------------------------------------------------------------------------
  // capture pin synchroniser and edge detect
  // -------------------------------------------------------------------------
  logic pin_meta_r;
  logic pin_sync_r;
  logic pin_prev_r;
  logic capture_evt;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      pin_meta_r <= 1'b0;
      pin_sync_r <= 1'b0;
      pin_prev_r <= 1'b0;
    end else begin
      pin_meta_r <= capture_trigger_pin;
      pin_sync_r <= pin_meta_r;
      pin_prev_r <= pin_sync_r;
    end
  end

  // edge select bit: 1 picks rising, 0 picks falling
  assign capture_evt = ctrl_r[CTRL_EDGE_BIT] ? (pin_sync_r & ~pin_prev_r)
                                              : (~pin_sync_r & pin_prev_r);

  // -------------------------------------------------------------------------
  // running count and capture register
  // -------------------------------------------------------------------------
  logic [15:0] count_r;
  logic [15:0] count_nxt;
  logic [15:0] capt_r;

  always_comb begin
    count_nxt = count_r + 16'h0001;
    if (wr_byte && avs_req.address == IDX_COUNT_HIGH) begin
      count_nxt = {avs_req.writedata[7:0], count_r[7:0]};
    end else if (wr_byte && avs_req.address == IDX_COUNT_LOW) begin
      count_nxt = {count_r[15:8], avs_req.writedata[7:0]};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      count_r <= COUNT_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      capt_r <= CAPT_RESET;
    end else if (capture_evt) begin
      capt_r <= count_r;
    end
  end

  // -------------------------------------------------------------------------
  // status register
  // -------------------------------------------------------------------------
  logic [7:0] status_r;
  logic [7:0] status_nxt;
  logic       status_wr;

  assign status_wr = wr_byte && avs_req.address == IDX_STATUS;

  always_comb begin
    status_nxt = status_r;
    if (status_wr) begin
      // flags only drop where a 0 is written; a 1 leaves them alone
      status_nxt[7:STAT_FLAG_LO] = status_r[7:STAT_FLAG_LO] & avs_req.writedata[7:4];
      status_nxt[STAT_FLAG_LO-1:0] = avs_req.writedata[3:0];
    end
    // set beats a clear arriving in the same cycle
    if (capture_evt) begin
      status_nxt[STAT_CAPT_BIT] = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      status_r <= STATUS_RESET;
    end else begin
      status_r <= status_nxt;
    end
  end

  // -------------------------------------------------------------------------
  // interrupt
  // -------------------------------------------------------------------------
  logic irq_r;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= status_r[STAT_CAPT_BIT] & ctrl_r[CTRL_IRQ_EN_BIT];
    end
  end

  assign capture_irq = irq_r;

  // -------------------------------------------------------------------------
  // read data
  // -------------------------------------------------------------------------
  logic [DATA_W-1:0] rdata_r;
  logic [7:0]        rbyte;

  always_comb begin
    unique case (avs_req.address)
      IDX_CTRL:       rbyte = ctrl_r;
      IDX_STATUS:     rbyte = status_r;
      IDX_COUNT_HIGH: rbyte = count_r[15:8];
      IDX_COUNT_LOW:  rbyte = count_r[7:0];
      IDX_CAPT_HIGH:  rbyte = capt_r[15:8];
      IDX_CAPT_LOW:   rbyte = capt_r[7:0];
      default:        rbyte = 8'h00;
    endcase
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rdata_r <= '0;
    end else if (req && wait_r && avs_req.read) begin
      rdata_r <= {{(DATA_W-8){1'b0}}, rbyte};
    end
  end

  assign avs_readdata = rdata_r;

  // -------------------------------------------------------------------------
  // assertions
  // -------------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  a_irq_enable_gate: assert property (
    !ctrl_r[CTRL_IRQ_EN_BIT] |=> !capture_irq)
    else $error("capture irq raised while disabled");

  a_capture_copies_count: assert property (
    capture_evt |=> capt_r == $past(count_r))
    else $error("capture register missed the count");

  a_capture_sets_flag: assert property (
    capture_evt |=> status_r[STAT_CAPT_BIT])
    else $error("capture flag not set");

  a_flag_one_write_keeps: assert property (
    status_wr && avs_req.writedata[7] && status_r[7] |=> status_r[7])
    else $error("write of one cleared the flag");

  a_flag_zero_clears: assert property (
    status_wr && !avs_req.writedata[STAT_CAPT_BIT] && !capture_evt
    |=> !status_r[STAT_CAPT_BIT])
    else $error("write of zero left a flag set");

  a_count_high_read: assert property (
    req && wait_r && avs_req.read && avs_req.address == IDX_COUNT_HIGH
    |=> avs_readdata[7:0] == $past(count_r[15:8]) && !avs_waitrequest)
    else $error("high byte read wrong");

  a_irq_follows_flag: assert property (
    status_r[STAT_CAPT_BIT] && ctrl_r[CTRL_IRQ_EN_BIT] |=> capture_irq)
    else $error("irq not raised for pending capture");

  a_irq_drops_on_clear: assert property (
    !status_r[STAT_CAPT_BIT] |=> !capture_irq)
    else $error("irq held after flag cleared");

  c_capture_event: cover property (capture_evt ##1 capture_irq);
  c_flag_cleared:  cover property (status_r[7] ##1 status_wr ##1 !status_r[7]);
  c_set_and_clear: cover property (status_wr && capture_evt);

endmodule

// ### test/trigger_model.sv
// partner model: external source driving the capture trigger pin
`timescale 1ns/100ps
module trigger_model (
  input  wire logic clk,   // system clock
  input  wire logic level, // level asked for by the bench
  output logic      pin    // capture trigger pin
);
  // steps only just after an edge and holds, so the synchroniser sees clean levels
  initial pin = 1'b0;
  always @(posedge clk) pin <= level;
endmodule

// ### test/tb_top.sv
// testbench: register access, capture, flag clearing and interrupt gating
`timescale 1ns/100ps
module tb_top;
  import frt_capture_pkg::*;
  typedef struct {logic [15:0] a; logic [7:0] d; logic [7:0] e;} row_t;
  logic              clk = 1'b0;
  logic              sys_rst = 1'b1;
  logic              level = 1'b0;
  avmm_req_t         req = '0;
  logic [DATA_W-1:0] rdata;
  logic              wreq;
  logic              irq;
  logic              pin;
  logic [7:0]        q;
  int                failures = 0;
  int                checked = 0;
  int                cyc = 0;
  int                c0;
  int                t0;
  int                cp;
  // plain register rows: address, write data, expected read-back
  row_t rows[3] = '{'{IDX_CTRL, 8'h81, 8'h81}, '{IDX_STATUS, 8'hff, 8'h0f},
                    '{16'hff96, 8'h55, 8'h00}};

  always #4 clk = ~clk;
  // a hang costs a mismatch; the whole run needs well under this
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 6000) begin
      failures++;
      end_of_test();
    end
  end

  free_running_timer_capture_status uut (.clk(clk), .sys_rst(sys_rst), .avs_req(req),
    .avs_readdata(rdata), .avs_waitrequest(wreq), .capture_trigger_pin(pin),
    .capture_irq(irq));
  trigger_model src (.clk(clk), .level(level), .pin(pin));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  // one avalon transfer, held until waitrequest is sampled low
  task automatic bus(input logic [15:0] a, input logic wr, input logic [7:0] d);
    @(posedge clk);
    req <= '{a, ~wr, wr, {24'h0, d}, 4'h1};
    do @(posedge clk); while (wreq !== 1'b0);
    q = rdata[7:0];
    c0 = cyc;
    req <= '0;
  endtask
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    bus(a, 1'b0, 8'h00);
    check({24'h0, q}, {24'h0, e});
  endtask
  task automatic trig(input logic v);
    @(posedge clk);
    level <= v;
    cp = cyc;
    repeat (8) @(posedge clk);
  endtask
  task end_of_test;
    if (failures == 0 && checked > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge clk);
    sys_rst <= 1'b0;
    rd(IDX_STATUS, 8'h00);
    check({31'h0, irq}, 32'h0);
    foreach (rows[i]) begin
      bus(rows[i].a, 1'b1, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    // low byte first so no carry disturbs the high byte
    bus(IDX_COUNT_LOW, 1'b1, 8'h00);
    t0 = c0;
    bus(IDX_COUNT_HIGH, 1'b1, 8'h12);
    rd(IDX_COUNT_HIGH, 8'h12);
    trig(1'b1);
    check({31'h0, irq}, 32'h1);
    rd(IDX_STATUS, 8'h8f);
    rd(IDX_CAPT_HIGH, 8'h12);
    bus(IDX_CAPT_LOW, 1'b0, 8'h00);
    check({31'h0, (int'(q) >= cp - t0) && (int'(q) <= cp - t0 + 8)}, 32'h1);
    bus(IDX_STATUS, 1'b1, 8'hf0);
    rd(IDX_STATUS, 8'h80);
    check({31'h0, irq}, 32'h1);
    bus(IDX_STATUS, 1'b1, 8'h00);
    rd(IDX_STATUS, 8'h00);
    check({31'h0, irq}, 32'h0);
    bus(IDX_CTRL, 1'b1, 8'h01);
    trig(1'b0);
    rd(IDX_STATUS, 8'h00);
    trig(1'b1);
    rd(IDX_STATUS, 8'h80);
    check({31'h0, irq}, 32'h0);
    bus(IDX_CTRL, 1'b1, 8'h81);
    repeat (3) @(posedge clk);
    check({31'h0, irq}, 32'h1);
    // falling edge select: clear the flag, then drop the pin
    bus(IDX_CTRL, 1'b1, 8'h80);
    bus(IDX_STATUS, 1'b1, 8'h00);
    trig(1'b0);
    rd(IDX_STATUS, 8'h80);
    check({31'h0, irq}, 32'h1);
    trig(1'b1);
    // pin falls so that its capture lands on the edge of a clearing write
    @(posedge clk);
    level <= 1'b0;
    @(posedge clk);
    bus(IDX_STATUS, 1'b1, 8'h00);
    rd(IDX_STATUS, 8'h80);
    // second reset in mid-run: registers and outputs back to idle values
    @(posedge clk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    check({31'h0, irq}, 32'h0);
    check({31'h0, wreq}, 32'h1);
    check(rdata, 32'h0);
    rd(IDX_CTRL, 8'h00);
    rd(IDX_STATUS, 8'h00);
    end_of_test();
  end
endmodule
